//--- verilog/cco_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cco_consts.svh"

// Function
// R1: Divider codes 0101, 0110, 0111 and 1000 divide by 8, 12, 16 and 24.
// R2: Channel B's divider resets to divide-by-4 or divide-by-3 by strap.
// R3: A channel clock is delayed by its 8-bit phase in input periods, reset 0.
// R4: LVPECL amplitude 00 is 350mV, 01 is 750mV, 1x is 1000mV; reset is 01.
// R5: One amplitude field serves both clock outputs of a channel pair.
// R6: Format and style 00 is LVDS, 01 LVPECL, 10 reserved and 11 AC-HCSL.
// R7: An output powers down only with format bit 0 and power-down bit 1.
// R8: A cleared enable holds the output low; the set reset value lets it run.
module cco_top (
   input  wire logic               i_clk_sys,
   input  wire logic               i_sys_rst,
   input  wire logic               i_second_divider_strap,
   input  wire logic               i_cfg_wr,
   input  wire logic               i_cfg_rd,
   input  wire logic [7:0]         i_cfg_addr,
   input  wire logic [7:0]         i_cfg_wdata,
   output logic [7:0]              o_cfg_rdata,
   output logic                    o_cfg_rvalid,
   output logic [3:0]              o_fanout_clock_output,
   output logic [3:0]              o_output_powered,
   output var cco_pkg::cco_fmt_t   o_fmt_pair_a,
   output var cco_pkg::cco_fmt_t   o_fmt_pair_b,
   output logic [10:0]             o_pair_a_shared_amplitude,
   output logic [10:0]             o_pair_b_shared_amplitude,
   output logic [1:0]              o_channel_tick
);
   import cco_pkg::*;

   logic        strap_s1_q, strap_s2_q;
   logic [3:0]  div_q   [2], div_d   [2];
   logic [7:0]  phase_q [2], phase_d [2];
   logic [1:0]  amp_q   [2], amp_d   [2];
   logic [1:0]  chpd_q,  chpd_d;
   logic [1:0]  style_q, style_d;
   logic [1:0]  fmt_q,   fmt_d;
   logic [1:0]  restart_q, restart_d;
   logic [3:0]  outpd_q, outpd_d;
   logic [3:0]  en_q,    en_d;
   logic [7:0]  rdata_d;
   logic [3:0]  fco_d,   pwr_d;
   cco_fmt_t    pfmt_d  [2];
   logic [10:0] mv_d    [2];
   logic [1:0]  lvl,     tck;
   logic [4:0]  fac     [2];

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [4:0] div_factor(input logic [3:0] code);
      case (code)                                              // [R1]
         4'h0:    div_factor = 5'h01;
         4'h1:    div_factor = 5'h02;
         4'h2:    div_factor = 5'h04;
         4'h3:    div_factor = 5'h03;
         4'h4:    div_factor = 5'h06;
         4'h5:    div_factor = 5'h08;
         4'h6:    div_factor = 5'h0C;
         4'h7:    div_factor = 5'h10;
         4'h8:    div_factor = 5'h18;
         default: div_factor = 5'h00;
      endcase
   endfunction

   function automatic logic [10:0] amp_mv(input cco_fmt_t f,
                                          input logic [1:0] a);
      amp_mv = `CCO_MV_NONE;
      if (f == CCO_FMT_LVDS || f == CCO_FMT_LVPECL) begin
         case (a)                                              // [R4]
            2'h0:    amp_mv = `CCO_MV_350;
            2'h1:    amp_mv = `CCO_MV_750;
            default: amp_mv = (f == CCO_FMT_LVPECL) ? `CCO_MV_1000
                                                    : `CCO_MV_NONE;
         endcase
      end
   endfunction

   function automatic logic [7:0] pair_byte(input logic pd,
                                            input logic sty,
                                            input logic [1:0] a,
                                            input logic fm);
      pair_byte = {pd, 2'h0, sty, a, fm, 1'b0};
   endfunction

   // ----------------------------------------------------------------------
   // Channel dividers
   // ----------------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ch
      cco_chan_if u_if ();
      assign fac[c]         = div_factor(div_q[c]);
      assign u_if.divisor   = fac[c];
      assign u_if.phase     = phase_q[c];
      assign u_if.restart   = restart_q[c];
      assign u_if.halt      = chpd_q[c] | (fac[c] == 5'h00);
      assign lvl[c]         = u_if.level;
      assign tck[c]         = u_if.tick;
      cco_chan_div u_div (
         .i_clk_sys (i_clk_sys),
         .i_sys_rst (i_sys_rst),
         .chan      (u_if.core)
      );
   end

   // ----------------------------------------------------------------------
   // Strap synchroniser
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      strap_s1_q <= i_second_divider_strap;
      strap_s2_q <= strap_s1_q;
   end

   // ----------------------------------------------------------------------
   // Register file and output logic
   // ----------------------------------------------------------------------
   always_comb begin
      div_d     = div_q;
      phase_d   = phase_q;
      amp_d     = amp_q;
      chpd_d    = chpd_q;
      style_d   = style_q;
      fmt_d     = fmt_q;
      outpd_d   = outpd_q;
      en_d      = en_q;
      restart_d = 2'h0;
      rdata_d   = o_cfg_rdata;
      if (i_cfg_wr) begin
         case (i_cfg_addr)
            `CCO_OFF_DIV: begin
               div_d[0]     = i_cfg_wdata[3:0];
               restart_d[0] = 1'b1;
            end
            `CCO_OFF_DIV + `CCO_CH_STRIDE: begin
               div_d[1]     = i_cfg_wdata[3:0];
               restart_d[1] = 1'b1;
            end
            `CCO_OFF_PHASE: begin
               phase_d[0]   = i_cfg_wdata;                     // [R3]
               restart_d[0] = 1'b1;
            end
            `CCO_OFF_PHASE + `CCO_CH_STRIDE: begin
               phase_d[1]   = i_cfg_wdata;                     // [R3]
               restart_d[1] = 1'b1;
            end
            `CCO_OFF_CHPD: chpd_d[0] = i_cfg_wdata[`CCO_BIT_PD];
            `CCO_OFF_CHPD + `CCO_CH_STRIDE:
               chpd_d[1] = i_cfg_wdata[`CCO_BIT_PD];
            `CCO_OFF_OUT0: begin
               outpd_d[0] = i_cfg_wdata[`CCO_BIT_PD];
               style_d[0] = i_cfg_wdata[`CCO_BIT_STYLE];
               amp_d[0]   = i_cfg_wdata[`CCO_BIT_AMP_HI:`CCO_BIT_AMP_LO];
               fmt_d[0]   = i_cfg_wdata[`CCO_BIT_FMT];
            end
            `CCO_OFF_OUT1: outpd_d[1] = i_cfg_wdata[`CCO_BIT_PD];
            `CCO_OFF_OUT0 + `CCO_CH_STRIDE: begin
               outpd_d[2] = i_cfg_wdata[`CCO_BIT_PD];
               style_d[1] = i_cfg_wdata[`CCO_BIT_STYLE];
               amp_d[1]   = i_cfg_wdata[`CCO_BIT_AMP_HI:`CCO_BIT_AMP_LO];
               fmt_d[1]   = i_cfg_wdata[`CCO_BIT_FMT];
            end
            `CCO_OFF_OUT1 + `CCO_CH_STRIDE:
               outpd_d[3] = i_cfg_wdata[`CCO_BIT_PD];
            `CCO_OFF_EN: en_d = {i_cfg_wdata[`CCO_BIT_EN_B1],
                                 i_cfg_wdata[`CCO_BIT_EN_B0],
                                 i_cfg_wdata[`CCO_BIT_EN_A1],
                                 i_cfg_wdata[`CCO_BIT_EN_A0]};
            default: ;
         endcase
      end
      if (i_cfg_rd) begin
         case (i_cfg_addr)
            `CCO_OFF_DIV:   rdata_d = {4'h0, div_q[0]};
            `CCO_OFF_DIV + `CCO_CH_STRIDE: rdata_d = {4'h0, div_q[1]};
            `CCO_OFF_PHASE: rdata_d = phase_q[0];
            `CCO_OFF_PHASE + `CCO_CH_STRIDE: rdata_d = phase_q[1];
            `CCO_OFF_CHPD:  rdata_d = {chpd_q[0], 7'h00};
            `CCO_OFF_CHPD + `CCO_CH_STRIDE: rdata_d = {chpd_q[1], 7'h00};
            `CCO_OFF_OUT0:  rdata_d = pair_byte(outpd_q[0], style_q[0],
                                                amp_q[0], fmt_q[0]);
            `CCO_OFF_OUT1:  rdata_d = {outpd_q[1], 7'h00};
            `CCO_OFF_OUT0 + `CCO_CH_STRIDE:
               rdata_d = pair_byte(outpd_q[2], style_q[1], amp_q[1],
                                   fmt_q[1]);
            `CCO_OFF_OUT1 + `CCO_CH_STRIDE: rdata_d = {outpd_q[3], 7'h00};
            `CCO_OFF_EN:    rdata_d = {en_q[0], en_q[1], 1'b0, en_q[2],
                                       en_q[3], 3'h0};
            default:        rdata_d = 8'h00;
         endcase
      end
      for (int y = 0; y < 4; y++) begin
         pwr_d[y] = fmt_q[y / 2] | ~outpd_q[y];                // [R7]
         fco_d[y] = lvl[y / 2] & en_q[y] & pwr_d[y]            // [R8]
                    & ~chpd_q[y / 2];
      end
      for (int c = 0; c < 2; c++) begin
         pfmt_d[c] = cco_fmt_t'({fmt_q[c], style_q[c]});      // [R6]
         mv_d[c]   = amp_mv(pfmt_d[c], amp_q[c]);              // [R5]
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         div_q[0]    <= `CCO_RST_DIV_A;
         div_q[1]    <= {`CCO_RST_DIV_B_HI, strap_s2_q};      // [R2]
         phase_q[0]  <= `CCO_RST_PHASE;                        // [R3]
         phase_q[1]  <= `CCO_RST_PHASE;
         amp_q[0]    <= `CCO_RST_AMP;                          // [R4]
         amp_q[1]    <= `CCO_RST_AMP;
         chpd_q      <= 2'h0;
         style_q     <= 2'h0;
         fmt_q       <= 2'h0;
         restart_q   <= 2'h0;
         outpd_q     <= 4'h0;
         en_q        <= `CCO_RST_EN;                           // [R8]
         o_cfg_rdata <= 8'h00;
         o_cfg_rvalid <= 1'b0;
         o_fanout_clock_output <= 4'h0;
         o_output_powered      <= 4'h0;
         o_fmt_pair_a <= CCO_FMT_LVDS;
         o_fmt_pair_b <= CCO_FMT_LVDS;
         o_pair_a_shared_amplitude <= `CCO_MV_NONE;
         o_pair_b_shared_amplitude <= `CCO_MV_NONE;
         o_channel_tick <= 2'h0;
      end else begin
         div_q       <= div_d;
         phase_q     <= phase_d;
         amp_q       <= amp_d;
         chpd_q      <= chpd_d;
         style_q     <= style_d;
         fmt_q       <= fmt_d;
         restart_q   <= restart_d;
         outpd_q     <= outpd_d;
         en_q        <= en_d;
         o_cfg_rdata <= rdata_d;
         o_cfg_rvalid <= i_cfg_rd;
         o_fanout_clock_output <= fco_d;
         o_output_powered      <= pwr_d;
         o_fmt_pair_a <= pfmt_d[0];
         o_fmt_pair_b <= pfmt_d[1];
         o_pair_a_shared_amplitude <= mv_d[0];
         o_pair_b_shared_amplitude <= mv_d[1];
         o_channel_tick <= tck & ~chpd_q;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   a_div8_period: assert property ( // [R1]
      ($rose(lvl[0]) && div_q[0] == 4'h5 && !restart_q[0])
      ##1 (div_q[0] == 4'h5 && !restart_q[0] && !chpd_q[0])[*7]
      |=> $rose(lvl[0]))
      else $error("divide-by-8 period is not eight cycles");

   a_div24_code: assert property ( // [R1]
      div_q[1] == 4'h8 |-> fac[1] == 5'h18)
      else $error("code 1000 does not select divide-by-24");

   a_strap_reset: assert property ( // [R2]
      $past(i_sys_rst) |-> div_q[1] == {3'h1, $past(strap_s2_q)})
      else $error("second divider reset value ignores strap");

   a_phase_reset: assert property ( // [R3]
      $past(i_sys_rst) |-> (phase_q[0] == 8'h00 && phase_q[1] == 8'h00))
      else $error("phase delay not zero after reset");

   a_amp_pecl_max: assert property ( // [R4]
      (fmt_q[0] == 1'b0 && style_q[0] && amp_q[0][1])
      |=> o_pair_a_shared_amplitude == 11'h3E8)
      else $error("LVPECL code 1x does not give 1000mV");

   a_amp_pair_shared: assert property ( // [R5]
      (i_cfg_wr && i_cfg_addr == 8'h25) |=> $stable(amp_q[0])
      ##1 $stable(o_pair_a_shared_amplitude))
      else $error("second output write changed the shared amplitude");

   a_fmt_hcsl: assert property ( // [R6]
      (fmt_q[1] && style_q[1]) |=> o_fmt_pair_b == CCO_FMT_HCSL)
      else $error("format 1 with style 1 is not AC-HCSL");

   a_pwr_format: assert property ( // [R7]
      fmt_q[0] |=> o_output_powered[1:0] == 2'h3)
      else $error("output powered down while format bit is set");

   a_pwr_down: assert property ( // [R7]
      (!fmt_q[1] && outpd_q[3]) |=> !o_output_powered[3]
      && !o_fanout_clock_output[3])
      else $error("output not powered down");

   a_enable_low: assert property ( // [R8]
      !en_q[2] [*2] |=> !o_fanout_clock_output[2])
      else $error("disabled output is not held low");

   c_div8_run: cover property ($rose(lvl[0]) && div_q[0] == 4'h5);
   c_hcsl_pair: cover property (o_fmt_pair_a == CCO_FMT_HCSL);
   c_strap_div3: cover property ($past(i_sys_rst) && div_q[1] == 4'h3);
   c_out_toggle: cover property ($rose(o_fanout_clock_output[3]));

endmodule // cco_top

`default_nettype wire

//--- verilog/cco_consts.svh
`ifndef CCO_CONSTS_SVH
`define CCO_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CCO_OFF_DIV       8'h20
`define CCO_OFF_PHASE     8'h21
`define CCO_OFF_CHPD      8'h22
`define CCO_OFF_OUT0      8'h24
`define CCO_OFF_OUT1      8'h25
`define CCO_CH_STRIDE     8'h10
`define CCO_OFF_EN        8'h74

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCO_BIT_PD        7
`define CCO_BIT_STYLE     4
`define CCO_BIT_AMP_HI    3
`define CCO_BIT_AMP_LO    2
`define CCO_BIT_FMT       1
`define CCO_BIT_EN_A0     7
`define CCO_BIT_EN_A1     6
`define CCO_BIT_EN_B0     4
`define CCO_BIT_EN_B1     3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCO_RST_DIV_A     4'h1
`define CCO_RST_DIV_B_HI  3'h1
`define CCO_RST_PHASE     8'h00
`define CCO_RST_AMP       2'h1
`define CCO_RST_EN        4'hF

// ----------------------------------------------------------------------
// Amplitude values in millivolts
// ----------------------------------------------------------------------
`define CCO_MV_NONE       11'h000
`define CCO_MV_350        11'h15E
`define CCO_MV_750        11'h2EE
`define CCO_MV_1000       11'h3E8

`endif

//--- verilog/cco_pkg.sv
package cco_pkg;

   typedef enum logic [1:0] {
      CCO_FMT_LVDS   = 2'h0,
      CCO_FMT_LVPECL = 2'h1,
      CCO_FMT_RSVD   = 2'h2,
      CCO_FMT_HCSL   = 2'h3
   } cco_fmt_t;

   typedef enum logic [1:0] {
      CCO_ST_IDLE  = 2'h0,
      CCO_ST_DELAY = 2'h1,
      CCO_ST_RUN   = 2'h3
   } cco_st_t;

endpackage

//--- verilog/cco_chan_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cco_chan_if;
   logic       halt;
   logic       restart;
   logic [4:0] divisor;
   logic [7:0] phase;
   logic       level;
   logic       tick;

   modport cfg  (output halt, output restart, output divisor,
                 output phase, input level, input tick);
   modport core (input halt, input restart, input divisor,
                 input phase, output level, output tick);
endinterface

`default_nettype wire

//--- verilog/cco_chan_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "cco_consts.svh"

module cco_chan_div (
   input  wire logic  i_clk_sys,
   input  wire logic  i_sys_rst,
   cco_chan_if.core   chan
);
   import cco_pkg::*;

   cco_st_t    st_q,   st_d;
   logic [7:0] dly_q,  dly_d;
   logic [4:0] cnt_q,  cnt_d;
   logic       lvl_q,  lvl_d;
   logic       tick_q, tick_d;
   logic [4:0] half;

   assign half       = 5'((6'(chan.divisor) + 6'h01) >> 1);
   assign chan.level = lvl_q;
   assign chan.tick  = tick_q;

   // ----------------------------------------------------------------------
   // Phase delay then divide
   // ----------------------------------------------------------------------
   always_comb begin
      st_d   = st_q;
      dly_d  = dly_q;
      cnt_d  = cnt_q;
      lvl_d  = 1'b0;
      tick_d = 1'b0;
      case (st_q)
         CCO_ST_IDLE: begin
            st_d  = CCO_ST_DELAY;
            dly_d = chan.phase;                                // [R3]
         end
         CCO_ST_DELAY: begin
            if (dly_q == 8'h00) begin
               st_d  = CCO_ST_RUN;
               cnt_d = 5'h00;
            end else begin
               dly_d = dly_q - 8'h01;                          // [R3]
            end
         end
         CCO_ST_RUN: begin
            if (cnt_q >= chan.divisor - 5'h01) begin           // [R1]
               cnt_d = 5'h00;
            end else begin
               cnt_d = cnt_q + 5'h01;
            end
            lvl_d  = (cnt_q < half);
            tick_d = (cnt_q == 5'h00);
         end
         default: begin
            st_d = CCO_ST_IDLE;
         end
      endcase
      // A halted or rewritten channel starts its delay over from idle.
      if (chan.halt || chan.restart) begin
         st_d  = CCO_ST_IDLE;
         lvl_d = 1'b0;
         tick_d = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st_q   <= CCO_ST_IDLE;
         dly_q  <= `CCO_RST_PHASE;
         cnt_q  <= 5'h00;
         lvl_q  <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         dly_q  <= dly_d;
         cnt_q  <= cnt_d;
         lvl_q  <= lvl_d;
         tick_q <= tick_d;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   a_delay_counts_down: assert property ( // [R3]
      (st_q == CCO_ST_DELAY && dly_q != 8'h00 && !chan.halt
       && !chan.restart) |=> (st_q == CCO_ST_DELAY
       && dly_q == $past(dly_q) - 8'h01))
      else $error("phase delay did not count down by one");

   a_delay_ends_run: assert property ( // [R3]
      (st_q == CCO_ST_DELAY && dly_q == 8'h00 && !chan.halt
       && !chan.restart) |=> (st_q == CCO_ST_RUN && !lvl_q)
       ##1 (lvl_q || chan.halt || chan.restart || $past(chan.halt)
       || $past(chan.restart)))
      else $error("clock did not start after phase delay");

   c_delay_long: cover property (
      st_q == CCO_ST_DELAY && dly_q == 8'h10);

endmodule // cco_chan_div

`default_nettype wire

//--- testbench/cco_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cco_consts.svh"

module cco_top_tb;
   import cco_pkg::*;

   logic              i_clk_sys;
   logic              i_sys_rst;
   logic              i_second_divider_strap;
   logic              i_cfg_wr;
   logic              i_cfg_rd;
   logic [7:0]        i_cfg_addr;
   logic [7:0]        i_cfg_wdata;
   logic [7:0]        o_cfg_rdata;
   logic              o_cfg_rvalid;
   logic [3:0]        o_fanout_clock_output;
   logic [3:0]        o_output_powered;
   cco_fmt_t          o_fmt_pair_a;
   cco_fmt_t          o_fmt_pair_b;
   logic [10:0]       o_pair_a_shared_amplitude;
   logic [10:0]       o_pair_b_shared_amplitude;
   logic [1:0]        o_channel_tick;
   int                err_count;
   int                checks;

   cco_top u_cco_top (
      .i_clk_sys                 (i_clk_sys),
      .i_sys_rst                 (i_sys_rst),
      .i_second_divider_strap    (i_second_divider_strap),
      .i_cfg_wr                  (i_cfg_wr),
      .i_cfg_rd                  (i_cfg_rd),
      .i_cfg_addr                (i_cfg_addr),
      .i_cfg_wdata               (i_cfg_wdata),
      .o_cfg_rdata               (o_cfg_rdata),
      .o_cfg_rvalid              (o_cfg_rvalid),
      .o_fanout_clock_output     (o_fanout_clock_output),
      .o_output_powered          (o_output_powered),
      .o_fmt_pair_a              (o_fmt_pair_a),
      .o_fmt_pair_b              (o_fmt_pair_b),
      .o_pair_a_shared_amplitude (o_pair_a_shared_amplitude),
      .o_pair_b_shared_amplitude (o_pair_b_shared_amplitude),
      .o_channel_tick            (o_channel_tick)
   );

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      i_cfg_wr    = 1'b1;
      i_cfg_addr  = addr;
      i_cfg_wdata = data;
      step(1);
      i_cfg_wr    = 1'b0;
      step(1);
   endtask

   task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
      i_cfg_rd   = 1'b1;
      i_cfg_addr = addr;
      step(1);
      i_cfg_rd   = 1'b0;
      check({15'h0000, o_cfg_rvalid}, 16'h0001);
      check({8'h00, o_cfg_rdata}, {8'h00, exp});
      step(1);
   endtask

   // Counts cycles from now to the next tick of one channel.
   task automatic to_tick(input int ch, output int n);
      n = 0;
      while (o_channel_tick[ch] !== 1'b1 && n < 600) begin
         step(1);
         n++;
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_values();
      rd_check(`CCO_OFF_DIV, 8'h01);
      rd_check(`CCO_OFF_DIV + `CCO_CH_STRIDE, 8'h03);
      rd_check(`CCO_OFF_PHASE, 8'h00);
      rd_check(`CCO_OFF_PHASE + `CCO_CH_STRIDE, 8'h00);
      rd_check(`CCO_OFF_OUT0, 8'h04);
      rd_check(`CCO_OFF_EN, 8'hD8);
      check({5'h00, o_pair_a_shared_amplitude}, {5'h00, `CCO_MV_750});
      wr(8'h23, 8'hFF);
      rd_check(8'h23, 8'h00);
   endtask

   task automatic t_divider();
      int n;
      int codes [4] = '{5, 6, 7, 8};
      int ratio [4] = '{8, 12, 16, 24};
      for (int i = 0; i < 4; i++) begin
         wr(`CCO_OFF_DIV, codes[i][7:0]);
         step(1);
         to_tick(0, n);
         step(1);
         to_tick(0, n);
         check(16'(n + 1), 16'(ratio[i]));
      end
   endtask

   task automatic t_phase();
      int n0;
      int n1;
      wr(`CCO_OFF_PHASE, 8'h00);
      step(1);
      to_tick(0, n0);
      step(30);
      wr(`CCO_OFF_PHASE, 8'h0A);
      step(1);
      to_tick(0, n1);
      check(16'(n1 - n0), 16'h000A);
      wr(`CCO_OFF_PHASE, 8'h00);
   endtask

   task automatic t_amplitude();
      logic [10:0] mv [4];
      mv = '{`CCO_MV_350, `CCO_MV_750, `CCO_MV_1000, `CCO_MV_1000};
      for (int a = 0; a < 4; a++) begin
         wr(`CCO_OFF_OUT0, 8'h10 | 8'(a << 2));
         step(1);
         check({5'h00, o_pair_a_shared_amplitude}, {5'h00, mv[a]});
      end
      wr(`CCO_OFF_OUT1, 8'h04);
      step(1);
      check({5'h00, o_pair_a_shared_amplitude}, {5'h00, `CCO_MV_1000});
      check({5'h00, o_pair_b_shared_amplitude}, {5'h00, `CCO_MV_750});
   endtask

   task automatic t_format();
      cco_fmt_t exp [4];
      exp = '{CCO_FMT_LVDS, CCO_FMT_LVPECL, CCO_FMT_RSVD, CCO_FMT_HCSL};
      for (int i = 0; i < 4; i++) begin
         wr(`CCO_OFF_OUT0, {3'h0, i[0], 2'h1, i[1], 1'b0});
         step(1);
         check({14'h0000, o_fmt_pair_a}, {14'h0000, exp[i]});
      end
   endtask

   task automatic t_power();
      wr(`CCO_OFF_OUT0, 8'h84);
      wr(`CCO_OFF_OUT1 + `CCO_CH_STRIDE, 8'h80);
      step(1);
      check({12'h000, o_output_powered}, 16'h0006);
      wr(`CCO_OFF_OUT0, 8'h86);
      wr(`CCO_OFF_OUT0 + `CCO_CH_STRIDE, 8'h16);
      step(1);
      check({12'h000, o_output_powered}, 16'h000F);
      check({14'h0000, o_fmt_pair_b}, {14'h0000, CCO_FMT_HCSL});
      wr(`CCO_OFF_OUT0, 8'h04);
      wr(`CCO_OFF_OUT0 + `CCO_CH_STRIDE, 8'h04);
      wr(`CCO_OFF_OUT1 + `CCO_CH_STRIDE, 8'h00);
      step(1);
   endtask

   task automatic t_enable();
      logic [3:0] seen;
      wr(`CCO_OFF_DIV, 8'h05);
      wr(`CCO_OFF_EN, 8'h48);
      step(20);
      seen = 4'h0;
      for (int i = 0; i < 24; i++) begin
         seen = seen | o_fanout_clock_output;
         step(1);
      end
      check({12'h000, seen}, 16'h000A);
      wr(`CCO_OFF_EN, 8'hD8);
      step(20);
      seen = 4'h0;
      for (int i = 0; i < 24; i++) begin
         seen = seen | o_fanout_clock_output;
         step(1);
      end
      check({12'h000, seen}, 16'h000F);
   endtask

   // ---------------------------------------------------------------
   // Verdict, clock and main sequence
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end

   initial begin
      #2000000;
      err_count++;
      give_verdict();
   end

   initial begin
      err_count              = 0;
      checks                 = 0;
      i_sys_rst              = 1'b1;
      i_second_divider_strap = 1'b1;
      i_cfg_wr               = 1'b0;
      i_cfg_rd               = 1'b0;
      i_cfg_addr             = 8'h00;
      i_cfg_wdata            = 8'h00;
      step(10);
      i_sys_rst = 1'b0;
      step(2);
      t_reset_values();
      t_divider();
      t_phase();
      t_amplitude();
      t_format();
      t_power();
      t_enable();
      give_verdict();
   end
endmodule // cco_top_tb

`default_nettype wire
